// File: hdl/adc_seq_consts.vh
// Constants for the converter control sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Register byte offsets on the bus
`define OFS_STATUS_CONTROL 8'h00
`define OFS_RESULT 8'h04

// Status/control field positions
`define BIT_COMPLETE 7
`define BIT_RC_SELECT 6
`define BIT_POWER_ON 5
`define CHAN_MSB 4
`define CHAN_LSB 0

// Reset values
`define RST_CHANNEL 5'h00
`define RST_RESULT 8'h00
`define RST_DATA 32'h0000_0000

// Sequencer timing in conversion clock cycles
`define CONV_STEPS 32
`define LAST_STEP 5'h1f
`define SAMPLE_STEPS 5'h04
`define LAST_PHASE 2'h3

// Channel codes
`define CHAN_LOW_GROUP_LAST 5'h07
`define CHAN_HIGH_GROUP_LAST 5'h0f
`define CHAN_REF_HIGH 5'h10
`define CHAN_REF_MID 5'h11
`define CHAN_REF_LOW 5'h12
`define CHAN_FACTORY_TEST 5'h13

`endif

// File: hdl/sync_two_stage.v
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
`default_nettype none

module sync_two_stage #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire arst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // sync_two_stage

`default_nettype wire

// File: hdl/adc_control_sequencer.v
// Control sequencer for the 8-bit successive-approximation converter
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_consts.vh"

module adc_control_sequencer (
    input wire clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire stop_mode,
    input wire rc_osc_in,
    input wire comparator_in,
    output reg rc_osc_en,
    output reg charge_pump_en,
    output reg comparator_en,
    output reg sample_hold,
    output reg [7:0] dac_code,
    output reg [4:0] mux_select,
    output reg conversion_done
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    // Halt marks a conversion cut short by stop
    localparam [2:0] ST_HALT = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg complete_reg;
    reg rc_select_reg;
    reg power_on_reg;
    reg [4:0] channel_reg;
    reg [7:0] result_reg;
    reg [4:0] step_reg;
    reg [4:0] step_next;
    reg [7:0] sar_reg;
    reg [7:0] sar_next;
    reg rc_prev_reg;
    reg [7:0] result_value;
    reg [31:0] read_mux;
    reg read_hit;

    wire rc_sync;
    wire cmp_sync;
    wire access;
    wire fire;
    wire wr_ctrl;
    wire rd_result;
    wire rc_edge;
    wire conv_tick;
    wire converting;
    wire done;
    wire sar_clear;
    wire [2:0] bit_index;
    wire [1:0] phase;
    wire [7:0] trial_mask;
    wire [7:0] wr_byte;

    // Stop comes from logic on this clock and needs no synchroniser
    // Oscillator and comparator are asynchronous to the bus clock
    sync_two_stage #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in({rc_osc_in, comparator_in}),
        .sync_out({rc_sync, cmp_sync})
    );

    // Bus handshake: one wait state, then pready for a single cycle
    assign access = psel & penable & ~pready;
    assign fire = psel & penable & pready;
    assign wr_ctrl = fire & pwrite & (paddr == `OFS_STATUS_CONTROL);
    assign rd_result = fire & ~pwrite & (paddr == `OFS_RESULT);
    assign wr_byte = pwdata[7:0];

    // clock source choice
    // Rising edges of the synchronised oscillator become one-cycle ticks
    // Oscillator must run well below half the bus clock or ticks are lost
    assign rc_edge = rc_sync & ~rc_prev_reg;
    assign conv_tick = rc_select_reg ? rc_edge : 1'b1;

    assign converting = (state_reg == ST_CONV);
    assign phase = step_reg[1:0];
    assign bit_index = 3'd7 - step_reg[4:2];
    assign trial_mask = 8'h01 << bit_index;

    // result handed over on a bus clock edge
    // stop in the last step aborts that result too
    assign done = converting & conv_tick & ~stop_mode & (step_reg == `LAST_STEP);

    // partial value discarded on restart or abort
    assign sar_clear = wr_ctrl | done | (state_next != ST_CONV);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rc_prev_reg <= 1'b0;
        end else begin
            rc_prev_reg <= rc_sync;
        end
    end

    // Successive approximation: set trial bit, decide it three steps later
    // Three ticks of margin cover the registered DAC and the synchroniser
    always @* begin
        sar_next = sar_reg;
        if (converting && conv_tick) begin
            if (phase == 2'h0) begin
                sar_next = sar_reg | trial_mask;
            // Comparator low means the trial bit overshot
            end else if (phase == `LAST_PHASE && !cmp_sync) begin
                sar_next = sar_reg & ~trial_mask;
            end
        end
    end

    // Channel decode for the final value
    always @* begin
        result_value = sar_next;
        if (channel_reg <= `CHAN_HIGH_GROUP_LAST) begin
            result_value = sar_next;
        // Reference channels share the comparator path
        end else if (channel_reg <= `CHAN_REF_LOW) begin
            result_value = sar_next;
        end else if (channel_reg == `CHAN_FACTORY_TEST) begin
            result_value = 8'h00;
        end else begin
            // Unused codes also read zero
            result_value = 8'h00;
        end
    end

    // Sequencer state
    // Only a control write moves the sequencer out of idle
    always @* begin
        state_next = state_reg;
        step_next = step_reg;
        case (state_reg)
            ST_IDLE: begin
                step_next = 5'h00;
            end
            ST_CONV: begin
                if (stop_mode) begin
                    state_next = ST_HALT;
                    step_next = 5'h00;
                // Power off drops back to idle at once
                end else if (!power_on_reg) begin
                    state_next = ST_IDLE;
                    step_next = 5'h00;
                end else if (conv_tick) begin
                    step_next = step_reg + 5'h01;
                end
            end
            ST_HALT: begin
                step_next = 5'h00;
                // Leaving stop with power on starts a fresh conversion from step zero, with power off returns to idle
                if (!stop_mode) begin
                    state_next = power_on_reg ? ST_CONV : ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                step_next = 5'h00;
            end
        endcase
        if (wr_ctrl) begin
            step_next = 5'h00;
            if (stop_mode) begin
                state_next = ST_HALT;
            end else if (wr_byte[`BIT_POWER_ON]) begin
                state_next = ST_CONV;
            end else begin
                state_next = ST_IDLE;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            step_reg <= 5'h00;
            sar_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            step_reg <= step_next;
            if (sar_clear) begin
                sar_reg <= 8'h00;
            end else begin
                sar_reg <= sar_next;
            end
        end
    end

    // Control fields; stop never touches them
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rc_select_reg <= 1'b0;
            power_on_reg <= 1'b0;
            channel_reg <= `RST_CHANNEL;
        end else if (wr_ctrl) begin
            // only bus writes change control
            // Writes made during stop still land
            rc_select_reg <= wr_byte[`BIT_RC_SELECT];
            power_on_reg <= wr_byte[`BIT_POWER_ON];
            channel_reg <= wr_byte[`CHAN_MSB:`CHAN_LSB];
        end
    end

    // Completion flag and result
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            complete_reg <= 1'b0;
            result_reg <= `RST_RESULT;
        end else begin
            // wait mode has no clearing term
            if (done) begin
                complete_reg <= 1'b1;
            end else if (wr_ctrl || rd_result) begin
                complete_reg <= 1'b0;
            end
            // A read racing a completion returns the old value, flag stays set
            // overwrite regardless of flag
            if (done) begin
                result_reg <= result_value;
            end
        end
    end

    // Read data multiplexer
    always @* begin
        read_mux = `RST_DATA;
        read_hit = 1'b1;
        case (paddr)
            `OFS_STATUS_CONTROL: begin
                read_mux[`BIT_COMPLETE] = complete_reg;
                read_mux[`BIT_RC_SELECT] = rc_select_reg;
                read_mux[`BIT_POWER_ON] = power_on_reg;
                read_mux[`CHAN_MSB:`CHAN_LSB] = channel_reg;
            end
            `OFS_RESULT: begin
                read_mux[7:0] = result_reg;
            end
            default: begin
                // Unmapped offsets answer with an error and zero data
                read_hit = 1'b0;
            end
        endcase
    end

    // Bus answer registers
    // Fixed single wait state lets read data come from a register
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= `RST_DATA;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            if (access) begin
                prdata <= pwrite ? `RST_DATA : read_mux;
                pslverr <= ~read_hit;
            end else begin
                prdata <= `RST_DATA;
                pslverr <= 1'b0;
            end
        end
    end

    // Analog side controls
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rc_osc_en <= 1'b0;
            charge_pump_en <= 1'b0;
            comparator_en <= 1'b0;
            sample_hold <= 1'b0;
            dac_code <= 8'h00;
            mux_select <= `RST_CHANNEL;
            conversion_done <= 1'b0;
        end else begin
            rc_osc_en <= rc_select_reg & ~stop_mode;
            // pump and comparator off in stop
            charge_pump_en <= power_on_reg & ~stop_mode;
            comparator_en <= power_on_reg & ~stop_mode;
            // Input sampled over the first bit trial
            sample_hold <= (state_next == ST_CONV) && (step_next < `SAMPLE_STEPS);
            // DAC returns to zero so the next conversion starts clean
            dac_code <= (wr_ctrl || done) ? 8'h00 : sar_next;
            mux_select <= channel_reg;
            conversion_done <= done;
        end
    end

endmodule // adc_control_sequencer

`default_nettype wire

// File: bench/adc_control_sequencer_chk.sv
// Assertions for the converter control sequencer ports
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_consts.vh"
module adc_control_sequencer_chk (
    input wire clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire stop_mode,
    input wire rc_osc_en,
    input wire charge_pump_en,
    input wire comparator_en,
    input wire sample_hold,
    input wire [4:0] mux_select,
    input wire conversion_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire wr_ctrl = psel && penable && pready && pwrite && paddr == `OFS_STATUS_CONTROL;
    a_ready_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read with data");
    a_stop_pump: assert property (stop_mode |=> !charge_pump_en && !comparator_en)
        else $error("pump on in stop");
    a_stop_rc: assert property (stop_mode |=> !rc_osc_en)
        else $error("oscillator on in stop");
    a_stop_done: assert property (stop_mode [*3] |-> !conversion_done)
        else $error("conversion in stop");
    a_done_gap: assert property (conversion_done |=> !conversion_done [*8])
        else $error("results too close");
    a_mux_follow: assert property (wr_ctrl |-> ##2 mux_select == $past(pwdata[4:0], 2))
        else $error("channel not applied");
    a_sample_start: assert property (
        wr_ctrl && pwdata[5] && !stop_mode |-> ##[1:4] sample_hold)
        else $error("no restart sample");
    a_stop_abort: assert property (stop_mode |=> !conversion_done)
        else $error("result after stop");
endmodule // adc_control_sequencer_chk

bind adc_control_sequencer adc_control_sequencer_chk u_chk (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stop_mode(stop_mode), .rc_osc_en(rc_osc_en), .charge_pump_en(charge_pump_en),
    .comparator_en(comparator_en), .sample_hold(sample_hold), .mux_select(mux_select),
    .conversion_done(conversion_done));
`default_nettype wire

// File: bench/adc_control_sequencer_tb.sv
// Self-checking testbench for the converter control sequencer
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_consts.vh"
module adc_control_sequencer_tb;
    logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic stop_mode = 1'h0, rc_osc_in = 1'h0, comparator_in = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rc_osc_en, charge_pump_en, comparator_en, sample_hold;
    logic conversion_done, rerr;
    logic [7:0] dac_code;
    logic [4:0] mux_select;
    logic [1:0] rc_div = 2'h0;
    int err_count = 0, n_compared = 0, seed = 35, n;
    logic [4:0] codes [9] = '{5'h00, 5'h07, 5'h08, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
    always #5 clk = ~clk;
    // conversion clock stays far above 1 MHz
    // Oscillator runs only while enabled, one tick every four bus cycles
    always @(posedge clk) begin
        rc_div <= rc_div + 2'h1;
        rc_osc_in <= rc_osc_en & rc_div[1];
    end
    adc_control_sequencer u_adc_control_sequencer (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .stop_mode(stop_mode), .rc_osc_in(rc_osc_in), .comparator_in(comparator_in),
        .rc_osc_en(rc_osc_en), .charge_pump_en(charge_pump_en), .comparator_en(comparator_en),
        .sample_hold(sample_hold), .dac_code(dac_code), .mux_select(mux_select),
        .conversion_done(conversion_done));
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Values before the edge's updates are read right after the edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (k >= 20) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic wait_done(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (conversion_done !== 1'h1 && c < 400);
        if (c >= 400) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic quiet(input string nm);
        int d = 0;
        repeat (100) begin
            @(posedge clk);
            if (conversion_done === 1'h1)
                d++;
        end
        chk(nm, d, 0);
    endtask
    // Test and unused codes always convert to zero
    function automatic logic [7:0] model(input logic [4:0] ch, input logic c);
        return (ch >= 5'h13) ? 8'h00 : {8{c}};
    endfunction
    initial begin
        logic [4:0] ch;
        logic c;
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        apb(1'h0, `OFS_STATUS_CONTROL, 32'h0);
        chk("ctrl_reset", rd, 32'h0);
        apb(1'h0, `OFS_RESULT, 32'h0);
        chk("result_reset", rd, 32'h0);
        apb(1'h1, `OFS_RESULT, 32'h0000_00a5);
        apb(1'h0, `OFS_RESULT, 32'h0);
        chk("result_ro", rd, 32'h0);
        chk("result_err", rerr, 1'h0);
        apb(1'h0, 8'h08, 32'h0);
        chk("unmapped_err", rerr, 1'h1);
        chk("unmapped_data", rd, 32'h0);
        $display("reset test done");
        foreach (codes[i]) begin
            ch = codes[i];
            // Codes that read zero get a high comparator so a wrong result shows
            c = (ch >= 5'h13) ? 1'h1 : 1'($random(seed));
            comparator_in <= c;
            // select kept clear at this fast bus clock
            apb(1'h1, `OFS_STATUS_CONTROL, {24'h0, 3'h1, ch});
            apb(1'h0, `OFS_STATUS_CONTROL, 32'h0);
            chk("ctrl_written", rd, {24'h0, 3'h1, ch});
            wait_done(n);
            apb(1'h0, `OFS_STATUS_CONTROL, 32'h0);
            chk("flag_set", rd, {24'h0, 3'h5, ch});
            apb(1'h0, `OFS_RESULT, 32'h0);
            chk("result", rd, {24'h0, model(ch, c)});
            chk("mux", mux_select, ch);
            apb(1'h0, `OFS_STATUS_CONTROL, 32'h0);
            chk("flag_cleared", rd[7], 1'h0);
        end
        $display("channel sweep done");
        ch = 5'h03;
        apb(1'h1, `OFS_STATUS_CONTROL, {24'h0, 3'h1, ch});
        repeat (2) @(posedge clk);
        chk("first_trial", {sample_hold, dac_code}, 9'h180);
        wait_done(n);
        comparator_in <= ~c;
        wait_done(n);
        wait_done(n);
        chk("period_bus", n, 32);
        apb(1'h0, `OFS_RESULT, 32'h0);
        chk("overwrite", rd, {24'h0, model(ch, ~c)});
        $display("overwrite test done");
        apb(1'h1, `OFS_STATUS_CONTROL, {24'h0, 3'h3, ch});
        repeat (2) @(posedge clk);
        chk("rc_on", {rc_osc_en, charge_pump_en}, 2'h3);
        // first RC result ignored while it settles
        wait_done(n);
        wait_done(n);
        chk("period_rc", n, 128);
        $display("rc clock test done");
        stop_mode <= 1'h1;
        comparator_in <= c;
        repeat (2) @(posedge clk);
        chk("stop_off", {rc_osc_en, charge_pump_en}, 2'h0);
        apb(1'h0, `OFS_STATUS_CONTROL, 32'h0);
        chk("stop_ctrl", rd[6:0], {2'h3, ch});
        chk("stop_idle", {sample_hold, dac_code}, 9'h000);
        quiet("stop_quiet");
        apb(1'h0, `OFS_RESULT, 32'h0);
        chk("stop_result", rd, {24'h0, model(ch, ~c)});
        stop_mode <= 1'h0;
        wait_done(n);
        apb(1'h0, `OFS_RESULT, 32'h0);
        chk("resume_result", rd, {24'h0, model(ch, c)});
        $display("stop test done");
        // power and select cleared while a conversion is running
        apb(1'h1, `OFS_STATUS_CONTROL, 32'h0);
        quiet("off_quiet");
        chk("off_idle", {rc_osc_en, charge_pump_en, dac_code}, 10'h000);
        $display("power off test done");
        wrap_up();
    end
endmodule // adc_control_sequencer_tb
`default_nettype wire
